/* File: hw/prescale_div.sv */
// module: power-of-two prescaler producing one-cycle count enables
module prescale_div #(
   parameter int LOG2_MAX = 7
) (
   // clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        rst_n,
   // control
   input  wire logic                        run,
   input  wire logic [$clog2(LOG2_MAX+1)-1:0] sel,
   // enable out
   output      logic                        tick
);

   // refuse depths that the mask and the divide counter cannot serve
   if (LOG2_MAX < 1 || LOG2_MAX > 15) begin : g_badDepth
      $error("prescale_div: LOG2_MAX out of range");
   end

   logic [LOG2_MAX-1:0] divCnt_r;
   logic [LOG2_MAX-1:0] mask;

   // mask of the low sel bits; tick when they are all ones
   assign mask = LOG2_MAX'((1 << sel) - 1);

   // free-run while enabled; restart on stop so the first period is full
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         divCnt_r <= '0;
      end else if (!run) begin
         divCnt_r <= '0;
      end else if ((divCnt_r & mask) == mask) begin
         divCnt_r <= '0;
      end else begin
         divCnt_r <= divCnt_r + 1'b1;
      end
   end

   assign tick = run && ((divCnt_r & mask) == mask);

endmodule : prescale_div

/* File: hw/reload_timer.sv */
// module: 16-bit reload timer with one-shot, continuous, counter and PWM modes
// Overview of operation
// - one-shot reload: event, count 0001h, self-disable
// - one-shot output inverts for one clock
// - timed modes count prescaled system clock
// - continuous reload: event, 0001h, output toggles
// - loaded start count affects first pass only
// - counter mode counts edges chosen by polarity
// - counter mode bypasses the prescaler
// - counter reload: event, 0001h, output toggles
// - counter polarity sets initial output level
// - PWM output toggles at match value
// - polarity one: high, low at match
// - polarity zero: low, high at match
// - PWM reload: event, 0001h, period ends
// - prescaler divides by 1 to 128
// - count wraps FFFFh to 0000h
module reload_timer (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // axi4-lite write address, data and response
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // timer pins
   input  wire logic        timerIn,
   output      logic        timerOut,
   output      logic        reloadPulse
);

   // ***************************************************
   // registers and bus slave
   // ***************************************************
   rtimer_pkg::ctrl_s ctrl_r;
   logic [15:0] count_r;
   logic [15:0] reload_r;
   logic [15:0] pwm_r;
   logic        evtFlag_r;
   logic        outLvl_r;
   logic        blip_r;
   logic [7:0]  awAddr_r;
   logic [31:0] wData_r;
   logic [3:0]  wStrb_r;
   logic        awHave_r;
   logic        wHave_r;
   logic        doWrite;
   logic        reloadHit;
   logic        advance;
   logic        pwmHit;
   logic        tick;
   logic        inSync_r;
   logic        inPrev_r;
   logic        edgeSeen;
   logic        clrEvt;

   // hold address and data until both are in; slave takes them in either order
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         awHave_r <= 1'b0;
         wHave_r  <= 1'b0;
         awAddr_r <= 8'h00;
         wData_r  <= 32'h0000_0000;
         wStrb_r  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end else if (doWrite) begin
            awHave_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end else if (doWrite) begin
            wHave_r <= 1'b0;
         end
      end
   end

   assign doWrite = awHave_r && wHave_r && !s_axi_bvalid;

   // ready only while the holding slot is empty and no response is pending
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
      end else begin
         s_axi_awready <= !awHave_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !wHave_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_r > rtimer_pkg::OFF_STATUS) ? 2'b10 : 2'b00;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel: one read at a time, unmapped addresses answer slverr
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= 2'b00;
         unique case (s_axi_araddr)
            rtimer_pkg::OFF_CTRL:   s_axi_rdata <= {24'h00_0000, ctrl_r};
            rtimer_pkg::OFF_COUNT:  s_axi_rdata <= {16'h0000, count_r};
            rtimer_pkg::OFF_RELOAD: s_axi_rdata <= {16'h0000, reload_r};
            rtimer_pkg::OFF_PWM:    s_axi_rdata <= {16'h0000, pwm_r};
            rtimer_pkg::OFF_STATUS: s_axi_rdata <= {30'h0000_0000, outLvl_r, evtFlag_r};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // ***************************************************
   // counting engine
   // ***************************************************
   // edge detect on the input; sampled as synchronous, so one stage suffices
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         inSync_r <= 1'b0;
         inPrev_r <= 1'b0;
      end else begin
         inSync_r <= timerIn;
         inPrev_r <= inSync_r;
      end
   end

   // polarity chooses rising (1) or falling (0); needs input at most clock/2
   assign edgeSeen = ctrl_r.output_polarity_sel ? (inSync_r && !inPrev_r)
                                                : (!inSync_r && inPrev_r);

   prescale_div #(
      .LOG2_MAX (rtimer_pkg::PRE_MAX_LOG2)
   ) u_pre (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .run     (ctrl_r.enable),
      .sel     (ctrl_r.preSel),
      .tick    (tick)
   );

   // counter mode skips the prescaler; other modes use the divided clock
   assign advance = ctrl_r.enable &&
                    ((ctrl_r.mode == rtimer_pkg::MODE_COUNTER) ? edgeSeen
                                                               : tick);
   assign reloadHit = advance && (count_r == reload_r);
   assign pwmHit    = advance && (ctrl_r.mode == rtimer_pkg::MODE_PWM) && (count_r == pwm_r);

   // count: restart at 0001h on reload, wrap naturally at FFFFh, hold when off
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= rtimer_pkg::COUNT_RST;
      end else if (doWrite && awAddr_r == rtimer_pkg::OFF_COUNT && !ctrl_r.enable) begin
         count_r <= wData_r[15:0];
      end else if (reloadHit) begin
         count_r <= rtimer_pkg::COUNT_RESTART;
      end else if (advance) begin
         count_r <= count_r + 16'h0001;
      end
   end

   // reload and pwm registers, writable only while stopped
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reload_r <= rtimer_pkg::RELOAD_RST;
         pwm_r    <= rtimer_pkg::PWM_RST;
      end else if (doWrite && !ctrl_r.enable) begin
         if (awAddr_r == rtimer_pkg::OFF_RELOAD) reload_r <= wData_r[15:0];
         if (awAddr_r == rtimer_pkg::OFF_PWM)    pwm_r    <= wData_r[15:0];
      end
   end

   // control: software write, one-shot clears its own enable after reload
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= '0;
      end else begin
         if (doWrite && awAddr_r == rtimer_pkg::OFF_CTRL && wStrb_r[0]) begin
            ctrl_r <= rtimer_pkg::ctrl_s'(wData_r[7:0]);
         end
         if (reloadHit && ctrl_r.mode == rtimer_pkg::MODE_ONESHOT) begin
            ctrl_r.enable <= 1'b0;
         end
      end
   end

   // sticky reload event; a new reload beats a same-cycle clear
   assign clrEvt = doWrite && awAddr_r == rtimer_pkg::OFF_STATUS && wData_r[rtimer_pkg::STAT_EVT_BIT];
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         evtFlag_r   <= 1'b0;
         reloadPulse <= 1'b0;
      end else begin
         reloadPulse <= reloadHit;
         if (reloadHit) begin
            evtFlag_r <= 1'b1;
         end else if (clrEvt) begin
            evtFlag_r <= 1'b0;
         end
      end
   end

   // ***************************************************
   // output level
   // ***************************************************
   // idle level follows polarity; modes toggle it or blip it for one clock
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         outLvl_r <= 1'b0;
         blip_r   <= 1'b0;
      end else begin
         blip_r <= 1'b0;
         if (!ctrl_r.enable) begin
            outLvl_r <= ctrl_r.output_polarity_sel;
         end else begin
            unique case (ctrl_r.mode)
               rtimer_pkg::MODE_ONESHOT: begin
                  // start level held while running, so a polarity flip lands at time-out
                  blip_r   <= reloadHit;
               end
               rtimer_pkg::MODE_CONT,
               rtimer_pkg::MODE_COUNTER: begin
                  if (reloadHit) outLvl_r <= !outLvl_r;
               end
               rtimer_pkg::MODE_PWM: begin
                  if (reloadHit) begin
                     outLvl_r <= ctrl_r.output_polarity_sel;
                  end else if (pwmHit) begin
                     outLvl_r <= !ctrl_r.output_polarity_sel;
                  end
               end
            endcase
         end
      end
   end

   // output pin registered; stays at polarity level when output function is off
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timerOut <= 1'b0;
      end else if (ctrl_r.outEn) begin
         timerOut <= blip_r ? !outLvl_r : outLvl_r;
      end else begin
         timerOut <= ctrl_r.output_polarity_sel;
      end
   end

   // ***************************************************
   // assertions
   // ***************************************************
   sequence s_reload;
      reloadHit;
   endsequence

   property p_restart;
      @(posedge ref_clk) disable iff (!rst_n)
      s_reload |=> (count_r == 16'h0001);
   endproperty
   a_restart: assert property (p_restart) else $error("count not 0001h after reload");

   property p_oneshot_stop;
      @(posedge ref_clk) disable iff (!rst_n)
      (s_reload and ctrl_r.mode == rtimer_pkg::MODE_ONESHOT) |=> !ctrl_r.enable;
   endproperty
   a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot did not stop");

   property p_blip;
      @(posedge ref_clk) disable iff (!rst_n)
      (s_reload and ctrl_r.mode == rtimer_pkg::MODE_ONESHOT && ctrl_r.outEn
       && outLvl_r == ctrl_r.output_polarity_sel
       && !(doWrite && awAddr_r == rtimer_pkg::OFF_CTRL))
      |=> ##1 (timerOut != outLvl_r) ##1 (timerOut == outLvl_r);
   endproperty
   a_blip: assert property (p_blip) else $error("one-shot blip wrong");

   property p_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      (!ctrl_r.enable && !doWrite) |=> $stable(count_r);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved while off");

   property p_wrap;
      @(posedge ref_clk) disable iff (!rst_n)
      (advance && !reloadHit && count_r == 16'hFFFF) |=> (count_r == 16'h0000);
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap at FFFFh");

   property p_counter_edge;
      @(posedge ref_clk) disable iff (!rst_n)
      (ctrl_r.enable && ctrl_r.mode == rtimer_pkg::MODE_COUNTER && !edgeSeen && !doWrite)
      |=> $stable(count_r);
   endproperty
   a_counter_edge: assert property (p_counter_edge) else $error("count without edge");

   property p_pwm_match;
      @(posedge ref_clk) disable iff (!rst_n)
      (pwmHit && !reloadHit && !(doWrite && awAddr_r == rtimer_pkg::OFF_CTRL))
      |=> (outLvl_r == !ctrl_r.output_polarity_sel);
   endproperty
   a_pwm_match: assert property (p_pwm_match) else $error("pwm match level wrong");

   property p_pwm_reload;
      @(posedge ref_clk) disable iff (!rst_n)
      (s_reload and ctrl_r.mode == rtimer_pkg::MODE_PWM
       && !(doWrite && awAddr_r == rtimer_pkg::OFF_CTRL))
      |=> (outLvl_r == ctrl_r.output_polarity_sel);
   endproperty
   a_pwm_reload: assert property (p_pwm_reload) else $error("pwm reload level wrong");

   property p_event;
      @(posedge ref_clk) disable iff (!rst_n)
      s_reload |=> (evtFlag_r && reloadPulse);
   endproperty
   a_event: assert property (p_event) else $error("reload event lost");

endmodule : reload_timer

/* File: shared/rtimer_pkg.sv */
// package: register map, field layout, reset values and modes of the reload timer
package rtimer_pkg;

   // ***************************************************
   // register offsets (byte addresses)
   // ***************************************************
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_COUNT  = 8'h04;
   localparam logic [7:0] OFF_RELOAD = 8'h08;
   localparam logic [7:0] OFF_PWM    = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;

   // ***************************************************
   // control field positions
   // ***************************************************
   localparam int CTRL_EN_BIT    = 0;
   localparam int CTRL_MODE_LSB  = 1;   // two bits
   localparam int CTRL_POL_BIT   = 3;
   localparam int CTRL_PRE_LSB   = 4;   // three bits, divide by 2**n
   localparam int CTRL_OUTEN_BIT = 7;
   localparam int STAT_EVT_BIT   = 0;   // reload seen, write 1 to clear
   localparam int STAT_OUT_BIT   = 1;

   // ***************************************************
   // reset values and fixed counts
   // ***************************************************
   localparam logic [15:0] COUNT_RST    = 16'h0000;
   localparam logic [15:0] RELOAD_RST   = 16'h0000;
   localparam logic [15:0] PWM_RST      = 16'h0000;
   localparam logic [15:0] COUNT_RESTART = 16'h0001;
   localparam int          PRE_MAX_LOG2 = 7;        // divide by up to 128

   // ***************************************************
   // modes and carriers
   // ***************************************************
   typedef enum logic [1:0] {
      MODE_ONESHOT = 2'h0,
      MODE_CONT    = 2'h1,
      MODE_COUNTER = 2'h2,
      MODE_PWM     = 2'h3
   } tmode_e;

   typedef struct packed {
      logic       outEn;
      logic [2:0] preSel;
      logic       output_polarity_sel;
      tmode_e     mode;
      logic       enable;
   } ctrl_s;

endpackage : rtimer_pkg

/* File: test/tb_reload_timer_oneshot_cont_count_pwm.sv */
// testbench: register bus driver, queue-based read checks and timer mode scenarios
module tb_reload_timer_oneshot_cont_count_pwm;
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************
   // signals and bookkeeping
   // ***************************************************
   logic        ref_clk, rst_n, timerIn, timerOut, reloadPulse;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          num_errors = 0;
   int          compares = 0;
   int          pulseCnt = 0, highCnt = 0, sinceCnt = 0, lastGap = 0, cyc = 0;
   logic [33:0] expQ[$];

   reload_timer u_reload_timer (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .timerIn, .timerOut, .reloadPulse);
   timer_in_src u_timer_in_src (.ref_clk, .timerIn);

   // 50 MHz clock
   initial ref_clk = 1'b0;
   always #10 ref_clk = ~ref_clk;

   // pulse count, gap between pulses and high time of the output pin
   always @(posedge ref_clk) begin
      cyc      <= cyc + 1;
      sinceCnt <= (reloadPulse === 1'b1) ? 1 : sinceCnt + 1;
      if (reloadPulse === 1'b1) begin
         pulseCnt <= pulseCnt + 1;
         lastGap  <= sinceCnt;
      end
      if (timerOut === 1'b1) highCnt <= highCnt + 1;
   end

   // each read answer is matched against the oldest note left by the driver
   always @(posedge ref_clk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         if (expQ.size() == 0) check(34'h0, 34'h1);
         else check({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
      end
   end

   // ***************************************************
   // tasks
   // ***************************************************
   task automatic check(input logic [33:0] seen, input logic [33:0] want);
      compares++;
      if (seen !== want) begin
         num_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic report_and_stop();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop

   // address and data offered together, each dropped when its ready is seen
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
      bit awDone, wDone;
      awDone = 0;
      wDone  = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!(awDone && wDone)) begin
         @(posedge ref_clk);
         if (!awDone && s_axi_awready === 1'b1) begin
            awDone = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wDone && s_axi_wready === 1'b1) begin
            wDone = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
      check(34'(s_axi_bresp), (a > rtimer_pkg::OFF_STATUS) ? 34'h2 : 34'h0);
      s_axi_bready <= 1'b0;
      @(posedge ref_clk);
   endtask : axiWrite

   task automatic axiRead(input logic [7:0] a, input logic [33:0] want);
      expQ.push_back(want);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      @(posedge ref_clk);
   endtask : axiRead

   function automatic logic [31:0] ctl(logic en, rtimer_pkg::tmode_e m, logic pol,
                                       logic [2:0] pre);
      rtimer_pkg::ctrl_s c;
      c = '{outEn: 1'b1, preSel: pre, output_polarity_sel: pol, mode: m, enable: en};
      return {24'h00_0000, c};
   endfunction : ctl

   // configure while stopped; the caller enables last
   task automatic setup(rtimer_pkg::tmode_e m, logic pol, logic [2:0] pre,
                        logic [15:0] cnt, logic [15:0] rld, logic [15:0] pw);
      axiWrite(rtimer_pkg::OFF_CTRL, ctl(1'b0, m, pol, pre));
      axiWrite(rtimer_pkg::OFF_COUNT, {16'h0000, cnt});
      axiWrite(rtimer_pkg::OFF_RELOAD, {16'h0000, rld});
      axiWrite(rtimer_pkg::OFF_PWM, {16'h0000, pw});
   endtask : setup

   task automatic waitPulse();
      int b;
      b = pulseCnt;
      while (pulseCnt == b) @(posedge ref_clk);
   endtask : waitPulse

   // ***************************************************
   // scenarios
   // ***************************************************
   initial begin
      int          base, b, c0, n, cnt, exPulses;
      logic        pol, lvl, o1;
      logic [15:0] pw;
      logic [2:0]  pre;
      rst_n = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      void'($urandom(51086));
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      s_axi_wstrb <= 4'hF;
      @(posedge ref_clk);
      // reset values, an unmapped address, direct write while stopped
      for (int a = 0; a <= 16; a += 4) axiRead(8'(a), 34'h0);
      axiRead(8'h14, {2'b10, 32'h0000_0000});
      axiWrite(8'h14, 32'h0000_0000);
      axiWrite(rtimer_pkg::OFF_COUNT, 32'h0000_1234);
      axiRead(rtimer_pkg::OFF_COUNT, {2'b00, 32'h0000_1234});
      // one-shot: a single one-clock blip, then stopped at 0001h
      setup(rtimer_pkg::MODE_ONESHOT, 1'b0, 3'h0, 16'h0001, 16'h0020, 16'h0000);
      base = highCnt;
      axiWrite(rtimer_pkg::OFF_CTRL, ctl(1'b1, rtimer_pkg::MODE_ONESHOT, 1'b0, 3'h0));
      waitPulse();
      repeat (6) @(posedge ref_clk);
      check(34'(highCnt - base), 34'h1);
      axiRead(rtimer_pkg::OFF_CTRL, {2'b00, ctl(1'b0, rtimer_pkg::MODE_ONESHOT, 1'b0, 3'h0)});
      axiRead(rtimer_pkg::OFF_COUNT, {2'b00, 32'h0000_0001});
      axiRead(rtimer_pkg::OFF_STATUS, {2'b00, 32'h0000_0001});
      axiWrite(rtimer_pkg::OFF_STATUS, 32'h0000_0001);
      axiRead(rtimer_pkg::OFF_STATUS, {2'b00, 32'h0000_0000});
      // lasting one-shot change: start low, flip polarity once running
      setup(rtimer_pkg::MODE_ONESHOT, 1'b0, 3'h0, 16'h0001, 16'h0020, 16'h0000);
      axiWrite(rtimer_pkg::OFF_CTRL, ctl(1'b1, rtimer_pkg::MODE_ONESHOT, 1'b0, 3'h0));
      axiWrite(rtimer_pkg::OFF_CTRL, ctl(1'b1, rtimer_pkg::MODE_ONESHOT, 1'b1, 3'h0));
      check(34'(timerOut), 34'h0);
      waitPulse();
      repeat (6) @(posedge ref_clk);
      check(34'(timerOut), 34'h1);
      // continuous at every prescale, first pass wraps through FFFFh
      for (int p = 0; p < 8; p++) begin
         setup(rtimer_pkg::MODE_CONT, 1'b0, 3'(p), 16'hFFFE, 16'h0006, 16'h0000);
         b  = pulseCnt;
         c0 = cyc;
         axiWrite(rtimer_pkg::OFF_CTRL, ctl(1'b1, rtimer_pkg::MODE_CONT, 1'b0, 3'(p)));
         axiWrite(rtimer_pkg::OFF_RELOAD, 32'h0000_0002);  // ignored while running
         while (pulseCnt == b) @(posedge ref_clk);
         check(34'((cyc - c0) <= (9 << p) + 20), 34'h1);
         waitPulse();
         o1 = timerOut;
         waitPulse();
         check(34'(lastGap), 34'(6 << p));
         check(34'(timerOut ^ o1), 34'h1);
      end
      // counter mode on both edges, prescaler at its largest to show bypass
      for (int k = 0; k < 2; k++) begin
         pol = (k == 0);
         setup(rtimer_pkg::MODE_COUNTER, pol, 3'h7, 16'h0001, 16'h0003, 16'h0000);
         repeat (3) @(posedge ref_clk);
         check(34'(timerOut), 34'(pol));
         axiWrite(rtimer_pkg::OFF_CTRL, ctl(1'b1, rtimer_pkg::MODE_COUNTER, pol, 3'h7));
         b = pulseCnt;
         n = 5 + $urandom % 4;
         cnt = 1;
         exPulses = 0;
         lvl = timerIn;
         for (int i = 0; i < n; i++) begin
            lvl = ~lvl;
            if (lvl == pol) begin
               if (cnt == 3) begin
                  cnt = 1;
                  exPulses++;
               end
               else cnt++;
            end
         end
         u_timer_in_src.toggleN(n);
         repeat (8) @(posedge ref_clk);
         axiRead(rtimer_pkg::OFF_COUNT, {2'b00, 32'(cnt)});
         check(34'(pulseCnt - b), 34'(exPulses));
         check(34'(timerOut), 34'(pol ^ exPulses[0]));
      end
      // pwm with both polarities, random match value below the reload
      for (int k = 0; k < 2; k++) begin
         pol = (k == 0);
         pw  = 16'(1 + $urandom % 6);
         pre = 3'($urandom % 3);
         setup(rtimer_pkg::MODE_PWM, pol, pre, 16'h0001, 16'h0008, pw);
         axiWrite(rtimer_pkg::OFF_CTRL, ctl(1'b1, rtimer_pkg::MODE_PWM, pol, pre));
         waitPulse();
         base = highCnt;
         repeat (4) waitPulse();
         check(34'(lastGap), 34'(8 << pre));
         check(34'(highCnt - base), 34'(((pol ? pw : 8 - pw) * 4) << pre));
      end
      report_and_stop();
   end

   // hang guard, well beyond the few thousand cycles the scenarios need
   initial begin
      repeat (40000) @(posedge ref_clk);
      num_errors++;
      report_and_stop();
   end
endmodule : tb_reload_timer_oneshot_cont_count_pwm

/* File: test/timer_in_src.sv */
// partner model: external source that toggles the timer input pin
module timer_in_src (
   // clock
   input  wire logic ref_clk,
   // timer input pin
   output      logic timerIn
);
   timeunit 1ns;
   timeprecision 1ps;

   // the pin idles low until the bench asks for edges
   initial timerIn = 1'b0;

   // each level is held four clocks, so edges come no faster than clk/4
   task automatic toggleN(input int n);
      for (int i = 0; i < n; i++) begin
         timerIn <= ~timerIn;
         repeat (4) @(posedge ref_clk);
      end
   endtask : toggleN
endmodule : timer_in_src
